// file: src/hcui_params.svh
// constants for the host configuration and microcontroller interrupt block
`ifndef HCUI_PARAMS_SVH
`define HCUI_PARAMS_SVH
`define HCUI_OFS_AUX         8'h2f
`define HCUI_OFS_IFC         8'h38
`define HCUI_OFS_BUFCTL      8'h37
`define HCUI_ADDR_AUX        12'h0bc
`define HCUI_ADDR_IFC        12'h0e0
`define HCUI_ADDR_BUFCTL     12'h0dc
`define HCUI_BIT_HOST_DMA_SELECT        7
`define HCUI_BIT_SLAVE       6
`define HCUI_BIT_BURST_CONTINUOUS        5
`define HCUI_BIT_IDD         4
`define HCUI_BIT_DRIVE_SELECT_MATCH        3
`define HCUI_BIT_CLOCK_SOURCE_STATUS        2
`define HCUI_BIT_W16         1
`define HCUI_BIT_SYNC_CLOCK_SWITCH        0
`define HCUI_BIT_BUSTYPE     7
`define HCUI_BIT_BURST_DMA_ENABLE        1
`define HCUI_BIT_DISK_POINTER_ARM        0
`define HCUI_BIT_SDH_DRV     4
`define HCUI_BIT_RAISE_HOST_INTERRUPT        7
`define HCUI_BIT_CLEAR_DRIVE_CHANGE        6
`define HCUI_BIT_CLEAR_SOFT_RESET        5
`define HCUI_BIT_CLEAR_FIFO_ERROR        4
`define HCUI_BIT_CLEAR_BUSY_FLAG        3
`define HCUI_BIT_CLEAR_HOST_POINTER_READY        2
`define HCUI_BIT_CLEAR_DISK_REQUEST        1
`define HCUI_BIT_CLEAR_COMMAND_SELECT        0
`define HCUI_AUX_RESET       8'h01
`define HCUI_BURST_8         5'h08
`define HCUI_BURST_16        5'h10
`define HCUI_BURST_NONE      5'h00
`endif

// file: src/hcui_pkg.sv
// types for the host configuration and microcontroller interrupt block
package hcui_pkg;
	typedef enum logic [2:0] {
		HCUI_CK_BUF  = 3'b001,
		HCUI_CK_GAP  = 3'b010,
		HCUI_CK_WCLK = 3'b100
	} hcui_ck_t;

	// events from the surrounding controller, one cycle or level each
	typedef struct packed {
		logic       sdh_write;
		logic [7:0] sdh_data;
		logic       cmd_write;
		logic       xt_select;
		logic       slave_irq;
		logic       soft_reset;
		logic       fifo_error;
		logic       disk_done;
		logic       disk_status_read;
		logic       disk_cmd_write;
		logic       xfer_zero;
		logic       fifo_empty;
		logic       host_ptr_armed;
		logic       ptr_pipe_load;
		logic       buffer_data_request_start;
	} hcui_events_t;

	// host interface mode outputs
	typedef struct packed {
		logic       use_dma;
		logic       slave_mode;
		logic       at_mode;
		logic       width16;
		logic       burst_cont;
		logic [4:0] burst_limit;
		logic       outputs_enable;
		logic       drive_selected;
	} hcui_mode_t;
endpackage

// file: src/hcui_core.sv
// host configuration, clock switch and microcontroller interrupt block
// Behaviour
// R1 - host dma bit set selects dma transfers, clear selects programmed i/o
// R2 - slave bit set makes host side a microcontroller-run slave
// R3 - slave mode with dma moves 8 or 16 bit transfers per width
// R4 - slave, idd, drive select and width clear only at power-up
// R5 - dma with burst: continuous if set, else 8 or 16 byte bursts
// R6 - idd set tri-states host data, irq and dma outputs when unselected
// R7 - at mode selected on sdh bit 4 match; xt mode on select bit
// R8 - width bit picks 8 or 16 bit host transfers
// R9 - switch bit moves drive clock glitch-free between buffer and write clock
// R10 - reset input holds buffer clock and sets switch bit
// R11 - software returns to write clock before drive commands
// R12 - status bit with switch bit reports source; mismatch means undefined
// R13 - software waits ten slow clock periods before reading clock status
// R14 - aux status reads back all control bits in place
// R15 - interrupt pin is or of seven flags; top status bit mirrors it
// R16 - at mode host change of sdh bit 4 sets drive-change flag
// R17 - soft reset and fifo over/underrun set their flags
// R18 - disk-done follows end-of-command, clears on status read or command
// R19 - host-pointer-ready sets on count zero/empty/unarmed or pipeline load
// R20 - disk request sets on transfer start; held while pointer unarmed
// R21 - command/select sets on at command, xt select, or slave irq rise
// R22 - bit 7 raises host interrupt; bit 6 clears drive-change flag
// R23 - software waits for host reset bit clear before clearing reset flag
// R24 - bits 4,2,1,0 clear their flags; bit 3 clears busy
// R25 - in master mode bus-type bit picks xt or at
// R26 - writing zero leaves flags and host interrupt unchanged
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "hcui_params.svh"

module hcui_core
	import hcui_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic         power_on_rst,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire hcui_events_t ev,
	input  wire logic         host_irq_enable,
	input  wire logic         buf_clk_alive,
	input  wire logic         wr_clk_alive,
	output hcui_mode_t        mode,
	output logic              sel_buf_clk,
	output logic              sel_wr_clk,
	output logic              uc_interrupt_pin,
	output logic              host_interrupt_request,
	output logic              clear_busy_flag,
	output logic              disk_pointer_arm
);
	typedef struct packed {
		logic [7:0] aux;
		logic [7:0] bufctl;
		logic [6:0] flags;
		logic       drq_hold;
		logic       sdh_bit;
		logic       slave_irq_d;
		logic [1:0] buf_alive_s;
		logic [1:0] wr_alive_s;
		logic [1:0] raise_host_interrupt_s;
		hcui_ck_t   ck;
		logic       clock_source_flag;
		logic       host_irq;
		logic       busy_clr;
		logic [31:0] rdata;
	} hcui_state_t;

	hcui_state_t st_reg;
	hcui_state_t st_next;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  wd;
	logic        at_mode;
	logic [6:0]  set_v;
	logic [6:0]  clr_v;
	logic        raise_host_interrupt_rise;

	// single-cycle apb answer keeps the master simple
	assign pready  = 1'b1;
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign wd      = pwdata[7:0];
	assign prdata  = st_reg.rdata;

	// address decode used only for the error response on unmapped addresses
	function automatic logic hit(input logic [11:0] a);
		hit = (a == `HCUI_ADDR_AUX) || (a == `HCUI_ADDR_IFC)
			|| (a == `HCUI_ADDR_BUFCTL);
	endfunction

	assign pslverr = psel & penable & ~hit(paddr);

	// master mode bus type; meaningless in slave mode [R25]
	assign at_mode = ~st_reg.aux[`HCUI_BIT_SLAVE]
		& st_reg.bufctl[`HCUI_BIT_BUSTYPE];
	assign raise_host_interrupt_rise = st_reg.raise_host_interrupt_s[1] & ~st_reg.slave_irq_d;

	// flag set sources, bit order matches interface status 6..0
	always_comb
	begin
		set_v[6] = at_mode & ev.sdh_write
			& (ev.sdh_data[`HCUI_BIT_SDH_DRV] != st_reg.sdh_bit); // [R16]
		set_v[5] = ev.soft_reset;                               // [R17]
		set_v[4] = ev.fifo_error;                               // [R17]
		set_v[3] = ev.disk_done;                                // [R18]
		set_v[2] = (ev.xfer_zero & ev.fifo_empty & ~ev.host_ptr_armed)
			| ev.ptr_pipe_load;                                 // [R19]
		set_v[1] = ev.buffer_data_request_start;                               // [R20]
		set_v[0] = (at_mode & ev.cmd_write)
			| (~st_reg.aux[`HCUI_BIT_SLAVE]
			& ~st_reg.bufctl[`HCUI_BIT_BUSTYPE] & ev.xt_select)
			| (st_reg.aux[`HCUI_BIT_SLAVE] & raise_host_interrupt_rise);        // [R21]
	end

	// write-one clears; zeros leave flags alone [R26]
	always_comb
	begin
		clr_v = 7'h00;
		if (wr_en && paddr == `HCUI_ADDR_IFC)
		begin
			clr_v[6] = wd[`HCUI_BIT_CLEAR_DRIVE_CHANGE];  // [R22]
			clr_v[5] = wd[`HCUI_BIT_CLEAR_SOFT_RESET];
			clr_v[4] = wd[`HCUI_BIT_CLEAR_FIFO_ERROR];  // [R24]
			clr_v[2] = wd[`HCUI_BIT_CLEAR_HOST_POINTER_READY];  // [R24]
			clr_v[1] = wd[`HCUI_BIT_CLEAR_DISK_REQUEST] & ~st_reg.drq_hold; // [R20]
			clr_v[0] = wd[`HCUI_BIT_CLEAR_COMMAND_SELECT];  // [R24]
		end
		// disk-done clears on status read or command write [R18]
		clr_v[3] = ev.disk_status_read | ev.disk_cmd_write;
	end

	// next-state logic for all state
	always_comb
	begin
		st_next = st_reg;
		st_next.busy_clr = 1'b0;
		st_next.host_irq = 1'b0;
		// synchronise pin-level inputs
		st_next.buf_alive_s = {st_reg.buf_alive_s[0], buf_clk_alive};
		st_next.wr_alive_s  = {st_reg.wr_alive_s[0], wr_clk_alive};
		st_next.raise_host_interrupt_s      = {st_reg.raise_host_interrupt_s[0], ev.slave_irq};
		st_next.slave_irq_d = st_reg.raise_host_interrupt_s[1];
		if (at_mode && ev.sdh_write)
			st_next.sdh_bit = ev.sdh_data[`HCUI_BIT_SDH_DRV];
		// set wins over clear
		st_next.flags = (st_reg.flags & ~clr_v) | set_v;
		// unarmed pointer at request start pins the flag [R20]
		if (ev.buffer_data_request_start && !st_reg.bufctl[`HCUI_BIT_DISK_POINTER_ARM])
			st_next.drq_hold = 1'b1;
		if (ev.buffer_data_request_start && st_reg.bufctl[`HCUI_BIT_DISK_POINTER_ARM])
			st_next.bufctl[`HCUI_BIT_DISK_POINTER_ARM] = 1'b0;
		if (wr_en && paddr == `HCUI_ADDR_AUX)
		begin
			// all control bits written in place; bit 2 reads status [R14]
			st_next.aux = wd & ~(8'h01 << `HCUI_BIT_CLOCK_SOURCE_STATUS);
		end
		else if (wr_en && paddr == `HCUI_ADDR_BUFCTL)
		begin
			st_next.bufctl = wd;
			if (wd[`HCUI_BIT_DISK_POINTER_ARM])
				st_next.drq_hold = 1'b0; // [R20]
		end
		else if (wr_en && paddr == `HCUI_ADDR_IFC)
		begin
			st_next.host_irq = wd[`HCUI_BIT_RAISE_HOST_INTERRUPT] & host_irq_enable; // [R22]
			st_next.busy_clr = wd[`HCUI_BIT_CLEAR_BUSY_FLAG];                   // [R24]
		end
		// glitch-free switch: stop old clock, gap, then start new [R9]
		case (st_reg.ck)
			HCUI_CK_BUF:
				if (!st_reg.aux[`HCUI_BIT_SYNC_CLOCK_SWITCH] && st_reg.buf_alive_s[1]
					&& st_reg.wr_alive_s[1])
					st_next.ck = HCUI_CK_GAP;
			HCUI_CK_WCLK:
				if (st_reg.aux[`HCUI_BIT_SYNC_CLOCK_SWITCH] && st_reg.buf_alive_s[1]
					&& st_reg.wr_alive_s[1])
					st_next.ck = HCUI_CK_GAP;
			HCUI_CK_GAP:
				st_next.ck = st_reg.aux[`HCUI_BIT_SYNC_CLOCK_SWITCH]
					? HCUI_CK_BUF : HCUI_CK_WCLK;
			default:
				st_next.ck = HCUI_CK_BUF;
		endcase
		st_next.clock_source_flag = (st_reg.ck == HCUI_CK_BUF); // [R12]
		// registered read data
		st_next.rdata = 32'h0000_0000;
		if (rd_en && paddr == `HCUI_ADDR_AUX)
		begin
			st_next.rdata[7:0] = st_reg.aux;
			st_next.rdata[`HCUI_BIT_CLOCK_SOURCE_STATUS] = st_reg.clock_source_flag; // [R12]
		end
		else if (rd_en && paddr == `HCUI_ADDR_IFC)
			st_next.rdata[7:0] = {|st_reg.flags, st_reg.flags};      // [R15]
		else if (rd_en && paddr == `HCUI_ADDR_BUFCTL)
			st_next.rdata[7:0] = st_reg.bufctl;
		// reset input: buffer clock and switch bit set [R10]
		if (srst)
		begin
			st_next.ck = HCUI_CK_BUF;
			st_next.aux[`HCUI_BIT_SYNC_CLOCK_SWITCH] = 1'b1;
			st_next.aux[`HCUI_BIT_HOST_DMA_SELECT] = 1'b0;
			st_next.aux[`HCUI_BIT_BURST_CONTINUOUS] = 1'b0;
			st_next.bufctl[`HCUI_BIT_DISK_POINTER_ARM] = 1'b0;
			st_next.bufctl[`HCUI_BIT_BURST_DMA_ENABLE] = 1'b0;
			st_next.flags = 7'h00;
			st_next.drq_hold = 1'b0;
			st_next.clock_source_flag = 1'b1;
			st_next.rdata = 32'h0000_0000;
		end
		// power-up clears everything but the switch bit, clock status flag and buffer clock select, including bits reset keeps [R4]
		if (power_on_rst)
		begin
			st_next = '0;
			st_next.aux = `HCUI_AUX_RESET;
			st_next.ck = HCUI_CK_BUF;
			st_next.clock_source_flag = 1'b1;
		end
	end

	// all state registered on one edge
	always_ff @(posedge sys_clk)
		st_reg <= st_next;

	// mode outputs
	always_comb
	begin
		mode.use_dma    = st_reg.aux[`HCUI_BIT_HOST_DMA_SELECT];           // [R1]
		mode.slave_mode = st_reg.aux[`HCUI_BIT_SLAVE];          // [R2]
		mode.at_mode    = at_mode;                              // [R25]
		mode.width16    = st_reg.aux[`HCUI_BIT_W16];            // [R8] [R3]
		mode.burst_cont = st_reg.aux[`HCUI_BIT_BURST_CONTINUOUS];
		// burst length bound by host width [R5]
		if (!(st_reg.aux[`HCUI_BIT_HOST_DMA_SELECT] && st_reg.bufctl[`HCUI_BIT_BURST_DMA_ENABLE])
			|| st_reg.aux[`HCUI_BIT_BURST_CONTINUOUS])
			mode.burst_limit = `HCUI_BURST_NONE;
		else if (st_reg.aux[`HCUI_BIT_W16])
			mode.burst_limit = `HCUI_BURST_16;
		else
			mode.burst_limit = `HCUI_BURST_8;
		// drive selection under intelligent decode [R7]
		if (st_reg.bufctl[`HCUI_BIT_BUSTYPE])
			mode.drive_selected = (st_reg.sdh_bit
				== st_reg.aux[`HCUI_BIT_DRIVE_SELECT_MATCH]);
		else
			mode.drive_selected = st_reg.aux[`HCUI_BIT_DRIVE_SELECT_MATCH];
		// gate host outputs when unselected [R6]
		mode.outputs_enable = ~st_reg.aux[`HCUI_BIT_IDD]
			| mode.drive_selected;
	end

	assign sel_buf_clk            = (st_reg.ck == HCUI_CK_BUF);   // [R9]
	assign sel_wr_clk             = (st_reg.ck == HCUI_CK_WCLK);  // [R9]
	assign uc_interrupt_pin       = |st_reg.flags;                // [R15]
	assign host_interrupt_request = st_reg.host_irq;
	assign clear_busy_flag        = st_reg.busy_clr;
	assign disk_pointer_arm       = st_reg.bufctl[`HCUI_BIT_DISK_POINTER_ARM];
endmodule

// file: verif/hcui_host_model.sv
// host side model turning bench kicks into controller events
`timescale 1ns/1ps

module hcui_host_model
	import hcui_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic [3:0] kick,
	output hcui_events_t    ev,
	output logic            buf_alive,
	output logic            wr_alive
);
	// both clocks stay present so a switch can always finish
	assign buf_alive = 1'b1;
	assign wr_alive  = 1'b1;
	// comb decode: one event per bench kick, one cycle wide
	always_comb
	begin
		ev = '0;
		ev.sdh_data = 8'h10;
		ev.fifo_empty = 1'b1;
		case (kick)
			4'h1: ev.sdh_write = 1'b1;
			4'h2: ev.soft_reset = 1'b1;
			4'h3: ev.fifo_error = 1'b1;
			4'h4: ev.xfer_zero = 1'b1;
			4'h5: ev.ptr_pipe_load = 1'b1;
			4'h6: ev.cmd_write = 1'b1;
			4'h7: ev.disk_done = 1'b1;
			4'h8: ev.disk_status_read = 1'b1;
			4'h9: ev.buffer_data_request_start = 1'b1;
			4'ha: ev.disk_cmd_write = 1'b1;
			4'hb: ev.xt_select = 1'b1;
			4'hc: ev.slave_irq = 1'b1;
			default: ev.sdh_write = 1'b0;
		endcase
	end
endmodule

// file: verif/hcui_chk.sv
// port checker for the host configuration block
`timescale 1ns/1ps
`include "hcui_params.svh"

module hcui_chk
	import hcui_pkg::*;
(
	input wire logic         sys_clk,
	input wire logic         srst,
	input wire logic         power_on_rst,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [11:0]  paddr,
	input wire logic [31:0]  pwdata,
	input wire hcui_events_t ev,
	input wire logic         host_irq_enable,
	input wire hcui_mode_t   mode,
	input wire logic         sel_buf_clk,
	input wire logic         sel_wr_clk,
	input wire logic         uc_interrupt_pin,
	input wire logic         host_interrupt_request,
	input wire logic         clear_busy_flag
);
	logic wr_ifc;
	logic wr_aux;
	// accepted writes, pready is always high
	assign wr_ifc = psel && penable && pwrite && paddr == `HCUI_ADDR_IFC;
	assign wr_aux = psel && penable && pwrite && paddr == `HCUI_ADDR_AUX;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst || power_on_rst);
	flag_set_a: assert property (
		ev.fifo_error || ev.soft_reset |=> uc_interrupt_pin)
		else $error("flag event did not raise the interrupt pin");
	irq_raise_a: assert property (
		wr_ifc && pwdata[7] && host_irq_enable |=> host_interrupt_request)
		else $error("host interrupt not raised");
	busy_clr_a: assert property (wr_ifc && pwdata[3] |=> clear_busy_flag)
		else $error("busy clear pulse missing");
	clk_excl_a: assert property (!(sel_buf_clk && sel_wr_clk))
		else $error("both clocks selected");
	rst_clk_a: assert property (
		disable iff (power_on_rst) srst |-> ##2 sel_buf_clk)
		else $error("buffer clock not selected after reset");
	keep_bits_a: assert property (
		disable iff (power_on_rst) srst |=> $stable(mode.width16)
		&& $stable(mode.slave_mode))
		else $error("retained bits changed by reset");
	dma_sel_a: assert property (
		wr_aux |=> mode.use_dma == $past(pwdata[7])
		&& mode.width16 == $past(pwdata[1]))
		else $error("mode bits do not follow aux write");
	burst_len_a: assert property (mode.burst_limit != 5'h00 |->
		mode.burst_limit == (mode.width16 ? `HCUI_BURST_16 : `HCUI_BURST_8))
		else $error("burst limit wrong for width");
	sel_gate_a: assert property (mode.drive_selected |-> mode.outputs_enable)
		else $error("selected drive has outputs off");
	// main scenarios
	cover property (host_interrupt_request);
	cover property (sel_wr_clk);
	cover property (uc_interrupt_pin);
endmodule

bind hcui_core hcui_chk u_chk (.sys_clk(sys_clk), .srst(srst),
	.power_on_rst(power_on_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ev(ev),
	.host_irq_enable(host_irq_enable), .mode(mode),
	.sel_buf_clk(sel_buf_clk), .sel_wr_clk(sel_wr_clk),
	.uc_interrupt_pin(uc_interrupt_pin), .clear_busy_flag(clear_busy_flag),
	.host_interrupt_request(host_interrupt_request));

// file: verif/host_config_and_uc_interrupts_tb.sv
// self-checking bench for the host configuration block
`timescale 1ns/1ps
`include "hcui_params.svh"
`define CK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
	err_total++; $display("ERROR %s exp %h got %h", n, e, s); end end

module host_config_and_uc_interrupts_tb;
	import hcui_pkg::*;
	logic         sys_clk = 1'b0;
	logic         srst = 1'b1;
	logic         power_on_rst = 1'b1;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic         host_irq_enable = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0;
	logic [3:0]   kick = 4'h0;
	logic [31:0]  prdata;
	logic         pready, pslverr, buf_alive, wr_alive, hir, cbf, serr;
	logic         sel_buf_clk, sel_wr_clk, uc_interrupt_pin;
	logic         host_interrupt_request, clear_busy_flag, disk_pointer_arm;
	logic [7:0]   rd;
	logic [7:0]   fb [1:6] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h04, 8'h01};
	hcui_events_t ev;
	hcui_mode_t   mode;
	int           err_total = 0;
	int           total_checks = 0;
	int           cyc = 0;

	hcui_host_model host (.sys_clk(sys_clk), .kick(kick), .ev(ev),
		.buf_alive(buf_alive), .wr_alive(wr_alive));
	hcui_core uut (.sys_clk(sys_clk), .srst(srst), .power_on_rst(power_on_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ev(ev), .host_irq_enable(host_irq_enable), .buf_clk_alive(buf_alive),
		.wr_clk_alive(wr_alive), .mode(mode), .sel_buf_clk(sel_buf_clk),
		.sel_wr_clk(sel_wr_clk), .uc_interrupt_pin(uc_interrupt_pin),
		.host_interrupt_request(host_interrupt_request),
		.clear_busy_flag(clear_busy_flag), .disk_pointer_arm(disk_pointer_arm));

	// clock and hang guard, the run needs well under a thousand cycles
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;
	always @(posedge sys_clk) if (cyc == 6000) end_sim(1'b1);

	// one apb transfer; read data is registered, so taken after the edge
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge sys_clk);
		rd = prdata[7:0];
		hir = host_interrupt_request;
		cbf = clear_busy_flag;
	endtask
	task rdc(input logic [11:0] a, input logic [7:0] e, input string n);
		apb(1'b0, a, 8'h00);
		`CK(n, e, rd)
	endtask
	task fire(input logic [3:0] k);
		@(posedge sys_clk);
		kick <= k;
		@(posedge sys_clk);
		kick <= 4'h0;
		@(negedge sys_clk);
	endtask

	task s_reset;
		rdc(`HCUI_ADDR_AUX, 8'h05, "aux rst");
		rdc(`HCUI_ADDR_IFC, 8'h00, "ifc rst");
	endtask
	// switch to write clock, then a reset must keep the retained bits
	task s_aux;
		apb(1'b1, `HCUI_ADDR_AUX, 8'hfa);
		repeat (12) @(posedge sys_clk);
		rdc(`HCUI_ADDR_AUX, 8'hfa, "aux rb");
		`CK("wrclk", 1'b1, sel_wr_clk)
		`CK("slave", 1'b1, mode.slave_mode)
		@(posedge sys_clk) srst <= 1'b1;
		@(posedge sys_clk) srst <= 1'b0;
		repeat (12) @(posedge sys_clk);
		rdc(`HCUI_ADDR_AUX, 8'h5f, "aux kept");
		apb(1'b1, `HCUI_ADDR_AUX, 8'h01);
	endtask
	// flags 6, 5, 4, 2 and 0: set, survive a zero write, clear by its own bit
	task s_flags;
		apb(1'b1, `HCUI_ADDR_BUFCTL, 8'h80);
		`CK("at", 1'b1, mode.at_mode)
		for (int k = 1; k <= 6; k++)
		begin
			fire(k[3:0]);
			`CK("pin", 1'b1, uc_interrupt_pin)
			rdc(`HCUI_ADDR_IFC, 8'h80 | fb[k], "set");
			apb(1'b1, `HCUI_ADDR_IFC, 8'h00);
			rdc(`HCUI_ADDR_IFC, 8'h80 | fb[k], "keep");
			apb(1'b1, `HCUI_ADDR_IFC, fb[k]);
			rdc(`HCUI_ADDR_IFC, 8'h00, "clr");
		end
		fire(4'h7);
		rdc(`HCUI_ADDR_IFC, 8'h88, "done");
		fire(4'h8);
		rdc(`HCUI_ADDR_IFC, 8'h00, "done rd");
		fire(4'h7);
		fire(4'ha);
		rdc(`HCUI_ADDR_IFC, 8'h00, "done cmd");
		fire(4'h9);
		apb(1'b1, `HCUI_ADDR_IFC, 8'h02);
		rdc(`HCUI_ADDR_IFC, 8'h82, "req held");
		apb(1'b1, `HCUI_ADDR_BUFCTL, 8'h81);
		apb(1'b1, `HCUI_ADDR_IFC, 8'h02);
		rdc(`HCUI_ADDR_IFC, 8'h00, "req clr");
		apb(1'b1, `HCUI_ADDR_BUFCTL, 8'h81);
		`CK("arm", 1'b1, disk_pointer_arm)
		fire(4'h9);
		`CK("arm used", 1'b0, disk_pointer_arm)
		apb(1'b1, `HCUI_ADDR_IFC, 8'h02);
		rdc(`HCUI_ADDR_IFC, 8'h00, "armed clr");
	endtask
	task s_misc;
		@(posedge sys_clk) host_irq_enable <= 1'b1;
		apb(1'b1, `HCUI_ADDR_IFC, 8'h80);
		`CK("hirq", 1'b1, hir)
		@(posedge sys_clk) host_irq_enable <= 1'b0;
		apb(1'b1, `HCUI_ADDR_IFC, 8'h88);
		`CK("hirq off", 1'b0, hir)
		`CK("busy", 1'b1, cbf)
		rdc(12'h004, 8'h00, "unmapped");
		`CK("slverr", 1'b1, serr)
		// slave irq passes a two-stage synchroniser before edge detect
		apb(1'b1, `HCUI_ADDR_AUX, 8'h41);
		fire(4'hc);
		repeat (3) @(posedge sys_clk);
		rdc(`HCUI_ADDR_IFC, 8'h81, "slave irq");
		apb(1'b1, `HCUI_ADDR_IFC, 8'h01);
		apb(1'b1, `HCUI_ADDR_AUX, 8'h01);
	endtask
	// burst limits and drive select gating
	task s_mode;
		apb(1'b1, `HCUI_ADDR_BUFCTL, 8'h82);
		apb(1'b1, `HCUI_ADDR_AUX, 8'h81);
		`CK("b8", `HCUI_BURST_8, mode.burst_limit)
		apb(1'b1, `HCUI_ADDR_AUX, 8'h83);
		`CK("b16", `HCUI_BURST_16, mode.burst_limit)
		apb(1'b1, `HCUI_ADDR_AUX, 8'ha3);
		`CK("bcont", 1'b1, mode.burst_cont)
		apb(1'b1, `HCUI_ADDR_AUX, 8'h19);
		`CK("sel", 1'b1, mode.outputs_enable)
		apb(1'b1, `HCUI_ADDR_AUX, 8'h11);
		`CK("tri", 1'b0, mode.outputs_enable)
		apb(1'b1, `HCUI_ADDR_BUFCTL, 8'h00);
		`CK("xt off", 1'b0, mode.outputs_enable)
		apb(1'b1, `HCUI_ADDR_AUX, 8'h19);
		`CK("xt sel", 1'b1, mode.outputs_enable)
		fire(4'hb);
		rdc(`HCUI_ADDR_IFC, 8'h81, "xt select");
		apb(1'b1, `HCUI_ADDR_IFC, 8'h01);
		rdc(`HCUI_ADDR_IFC, 8'h00, "xt clr");
	endtask

	task end_sim(input logic to);
		if (to)
			err_total++;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		power_on_rst <= 1'b0;
		s_reset;
		s_aux;
		s_flags;
		s_misc;
		s_mode;
		end_sim(1'b0);
	end
endmodule
